// ---- blpm_ctrl.sv ----
// Purpose: Boot source selection, start-up fetch and low-power modes
// Assumes: Memory read data arrives the cycle after memRd
// Notes: Brownout flags act as synchronous reset sources
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module blpm_ctrl #(
    parameter int NP = 32,
    parameter int SETTLE = blpm_pkg::SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic borVddLow,
    input wire logic borVddaLow,
    input wire logic bootSelPin,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic memRd,
    output logic [31:0] memAddr,
    input wire logic [31:0] memRdata,
    output logic [31:0] bootBase,
    output logic [31:0] cpuStackPtr,
    output logic [31:0] cpuResetPc,
    output logic cpuRunEn,
    input wire logic cpuWfi,
    input wire logic cpuExitLowest,
    input wire logic [31:0] irqPending,
    output logic extFastOscEn,
    output logic intFastOscEn,
    output logic extSlowOscEn,
    output logic intSlowOscEn,
    input wire logic extFastOscRdy,
    input wire logic intFastOscRdy,
    output logic [1:0] sysClkSel,
    input wire logic [NP-1:0] periphWrReq,
    output logic [NP-1:0] periphWrEn,
    output logic [NP-1:0] cfgClkEn,
    output logic [NP-1:0] workClkEn,
    output logic sysRstOut
);
    // Elaboration-time refusal of peripheral counts the words cannot serve
    if (NP < 2 || NP > 32) begin : g_np_chk
        $error("blpm_ctrl: NP must be 2..32");
    end

    blpm_pkg::blpm_state_t state_r, state_nxt;
    logic sysRst;
    logic deepSel_r, sleepAfter_r, wakeClk_r;
    logic swExtFast_r, swIntFast_r;
    blpm_pkg::blpm_clk_t clkSel_r;
    logic [NP-1:0] cfgEn_r, workEn_r;
    logic [31:0] irqEn_r;
    logic loader_r;
    logic extStable, intStable;

    ////////////////////////////////////////////////////////////////////////
    // Reset sources: pin reset plus supply monitors on either rail
    assign sysRst = srst | borVddLow | borVddaLow; // [RULE_15]
    assign sysRstOut = sysRst;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    wire wrCtrl = regWr && (regAddr == blpm_pkg::OFS_CTRL);
    wire wrCfg = regWr && (regAddr == blpm_pkg::OFS_CFG_EN);
    wire wrWork = regWr && (regAddr == blpm_pkg::OFS_WORK_EN);
    wire wrIrq = regWr && (regAddr == blpm_pkg::OFS_IRQ_EN);

    // Mode events
    wire inActive = (state_r == blpm_pkg::ST_ACTIVE);
    wire sleepReq = cpuWfi | (sleepAfter_r & cpuExitLowest); // [RULE_12] [RULE_13]
    wire wakeReq = |(irqPending & irqEn_r); // [RULE_14]
    wire inDeep = (state_r == blpm_pkg::ST_DEEP);
    wire deepWake = inDeep && wakeReq;

    // Selected system clock is usable; slow sources need no wait
    wire selStable = (clkSel_r == blpm_pkg::CLK_INT) ? intStable :
                     (clkSel_r == blpm_pkg::CLK_EXT) ? extStable : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            blpm_pkg::ST_CAPT: state_nxt = blpm_pkg::ST_FSP;
            blpm_pkg::ST_FSP: state_nxt = blpm_pkg::ST_FPC;
            blpm_pkg::ST_FPC: state_nxt = blpm_pkg::ST_LPC;
            blpm_pkg::ST_LPC: state_nxt = blpm_pkg::ST_ACTIVE; // [RULE_09]
            blpm_pkg::ST_ACTIVE: begin
                if (sleepReq) begin
                    state_nxt = deepSel_r ? blpm_pkg::ST_DEEP
                                          : blpm_pkg::ST_SLEEP; // [RULE_12]
                end
            end
            blpm_pkg::ST_SLEEP: begin
                if (wakeReq) begin
                    state_nxt = blpm_pkg::ST_ACTIVE; // [RULE_14]
                end
            end
            blpm_pkg::ST_DEEP: begin
                if (wakeReq) begin
                    state_nxt = blpm_pkg::ST_WAKE;
                end
            end
            blpm_pkg::ST_WAKE: begin
                if (selStable) begin
                    state_nxt = blpm_pkg::ST_ACTIVE; // [RULE_20]
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            state_r <= blpm_pkg::ST_CAPT;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot pin is looked at in the first cycle after release and never again
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            loader_r <= 1'b0;
        end else if (state_r == blpm_pkg::ST_CAPT) begin
            loader_r <= bootSelPin; // [RULE_01] [RULE_02]
        end
    end
    assign bootBase = loader_r ? blpm_pkg::BASE_LOADER
                               : blpm_pkg::BASE_FLASH; // [RULE_02]

    ////////////////////////////////////////////////////////////////////////
    // Start-up fetch: stack word, then vector word, one read each
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            memRd <= 1'b0;
            memAddr <= blpm_pkg::ADDR_STACK;
            cpuStackPtr <= 32'h00000000;
            cpuResetPc <= 32'h00000000;
        end else begin
            memRd <= (state_r == blpm_pkg::ST_CAPT)
                  || (state_r == blpm_pkg::ST_FSP); // [RULE_04]
            if (state_r == blpm_pkg::ST_FSP) begin
                memAddr <= blpm_pkg::ADDR_VECTOR; // [RULE_04]
            end
            if (state_r == blpm_pkg::ST_FPC) begin
                cpuStackPtr <= memRdata; // [RULE_04]
            end
            if (state_r == blpm_pkg::ST_LPC) begin
                cpuResetPc <= memRdata; // [RULE_04]
            end
        end
    end

    // Core runs only in active mode; sleep leaves everything else alone
    assign cpuRunEn = inActive; // [RULE_10] [RULE_11]

    ////////////////////////////////////////////////////////////////////////
    // Control register; a deep-sleep wake with wake clock select set beats a software clock write
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            deepSel_r <= 1'b0;
            sleepAfter_r <= 1'b0;
            wakeClk_r <= 1'b0;
            clkSel_r <= blpm_pkg::CLK_INT;
            swExtFast_r <= 1'b0;
            swIntFast_r <= blpm_pkg::RST_INT_FAST;
            extSlowOscEn <= 1'b0;
            intSlowOscEn <= 1'b0;
        end else begin
            if (wrCtrl) begin
                deepSel_r <= regWdata[blpm_pkg::CTRL_DEEP_SEL];
                sleepAfter_r <= regWdata[blpm_pkg::CTRL_SLEEP_AFTER];
                wakeClk_r <= regWdata[blpm_pkg::CTRL_WAKE_CLK];
                clkSel_r <= blpm_pkg::blpm_clk_t'(
                    regWdata[blpm_pkg::CTRL_CLK_SEL +: 2]);
                swExtFast_r <= regWdata[blpm_pkg::CTRL_EXT_FAST];
                swIntFast_r <= regWdata[blpm_pkg::CTRL_INT_FAST];
                extSlowOscEn <= regWdata[blpm_pkg::CTRL_EXT_SLOW]; // [RULE_11]
                intSlowOscEn <= regWdata[blpm_pkg::CTRL_INT_SLOW];
            end
            if (deepWake && wakeClk_r) begin
                clkSel_r <= blpm_pkg::CLK_INT; // [RULE_19]
            end
        end
    end
    assign sysClkSel = clkSel_r;

    // Clock enable and wake interrupt enable words
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            cfgEn_r <= blpm_pkg::RST_CLK_EN[NP-1:0]; // [RULE_05]
            workEn_r <= blpm_pkg::RST_CLK_EN[NP-1:0]; // [RULE_05]
            irqEn_r <= blpm_pkg::RST_IRQ_EN;
        end else begin
            if (wrCfg) begin
                cfgEn_r <= regWdata[NP-1:0];
            end
            if (wrWork) begin
                workEn_r <= regWdata[NP-1:0];
            end
            if (wrIrq) begin
                irqEn_r <= regWdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fast oscillators: off in deep sleep, the clock in use is kept on
    wire wantInt = (clkSel_r == blpm_pkg::CLK_INT)
                 || (deepWake && wakeClk_r);
    wire wantExt = (clkSel_r == blpm_pkg::CLK_EXT) && !(deepWake && wakeClk_r);
    wire fastOff = inDeep && !wakeReq; // [RULE_11]

    blpm_osc_ctrl #(.SETTLE(SETTLE)) uExtOsc (
        .core_clk(core_clk),
        .srst(sysRst),
        .swEn(swExtFast_r),
        .forceOn(wantExt),
        .forceOff(fastOff),
        .oscRdy(extFastOscRdy),
        .oscEn(extFastOscEn),
        .oscStable(extStable)
    );

    blpm_osc_ctrl #(.SETTLE(SETTLE)) uIntOsc (
        .core_clk(core_clk),
        .srst(sysRst),
        .swEn(swIntFast_r),
        .forceOn(wantInt),
        .forceOff(fastOff),
        .oscRdy(intFastOscRdy),
        .oscEn(intFastOscEn),
        .oscStable(intStable)
    );

    blpm_periph_gate #(.NP(NP)) uGate (
        .cfgEnReg(cfgEn_r),
        .workEnReg(workEn_r),
        .periphWrReq(periphWrReq),
        .cfgClkEn(cfgClkEn),
        .workClkEn(workClkEn),
        .periphWrEn(periphWrEn)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped offsets read as zero
    wire [31:0] ctrlWord = {20'h00000, intSlowOscEn, extSlowOscEn,
                            swIntFast_r, swExtFast_r, 2'b00, clkSel_r,
                            1'b0, wakeClk_r, sleepAfter_r, deepSel_r};
    wire [31:0] statWord = {25'h0000000, intStable, extStable, loader_r,
                            1'b0, state_r};
    wire [31:0] rdMux =
        (regAddr == blpm_pkg::OFS_CTRL) ? ctrlWord :
        (regAddr == blpm_pkg::OFS_CFG_EN) ? 32'(cfgEn_r) :
        (regAddr == blpm_pkg::OFS_WORK_EN) ? 32'(workEn_r) :
        (regAddr == blpm_pkg::OFS_STATUS) ? statWord :
        (regAddr == blpm_pkg::OFS_IRQ_EN) ? irqEn_r : 32'h00000000;

    always_ff @(posedge core_clk) begin
        if (sysRst || !regRd) begin
            regRdata <= 32'h00000000;
        end else begin
            regRdata <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sysRst);

    // Gate pattern expected in the first cycle after any reset
    wire [NP-1:0] rstOn = (NP'(1) << blpm_pkg::TICK_IDX)
                        | (NP'(1) << blpm_pkg::SRAM_IDX);

    sequence s_fetch_sp;
        memRd && memAddr == blpm_pkg::ADDR_STACK;
    endsequence
    sequence s_fetch_pc;
        memRd && memAddr == blpm_pkg::ADDR_VECTOR;
    endsequence

    // Sampled reset guard: the release edge itself still shows CAPT
    a_boot_sample: assert property ( // [RULE_01]
        !sysRst && state_r == blpm_pkg::ST_CAPT
        |=> loader_r == $past(bootSelPin))
        else $error("boot pin not captured at release");
    a_boot_hold: assert property ( // [RULE_02]
        state_r != blpm_pkg::ST_CAPT |=> $stable(loader_r))
        else $error("boot source changed after release");
    a_vec_fetch: assert property ( // [RULE_04]
        !sysRst && state_r == blpm_pkg::ST_CAPT |=> s_fetch_sp ##1 s_fetch_pc
        ##1 cpuStackPtr == $past(memRdata) ##1 inActive)
        else $error("start-up fetch order wrong");
    a_gate_on: assert property ( // [RULE_05]
        cfgClkEn[blpm_pkg::SRAM_IDX] && workClkEn[blpm_pkg::TICK_IDX]
        && cfgClkEn[blpm_pkg::TICK_IDX] && workClkEn[blpm_pkg::SRAM_IDX]
        && (!$past(sysRst) || (cfgClkEn == rstOn && workClkEn == rstOn)))
        else $error("clock gating wrong after reset");
    a_wr_drop: assert property ( // [RULE_07]
        (periphWrEn & ~cfgClkEn) == '0)
        else $error("write passed to gated peripheral");
    a_sleep_entry: assert property ( // [RULE_12]
        inActive && cpuWfi |=> !cpuRunEn && state_r ==
        (($past(deepSel_r)) ? blpm_pkg::ST_DEEP : blpm_pkg::ST_SLEEP))
        else $error("wait instruction did not enter low power");
    a_exit_entry: assert property ( // [RULE_13]
        inActive && cpuExitLowest && sleepAfter_r |=> !cpuRunEn)
        else $error("sleep after handler not entered");
    a_deep_osc: assert property ( // [RULE_11]
        inDeep ##1 inDeep |-> !extFastOscEn && !intFastOscEn)
        else $error("fast oscillator left on in deep sleep");
    a_sleep_wake: assert property ( // [RULE_14]
        state_r == blpm_pkg::ST_SLEEP && wakeReq |=> cpuRunEn)
        else $error("sleep not ended by enabled interrupt");
    a_wake_clk: assert property ( // [RULE_19]
        deepWake && wakeClk_r |=> sysClkSel == blpm_pkg::CLK_INT)
        else $error("wake did not select internal clock");
    a_wake_hold: assert property ( // [RULE_20]
        state_r == blpm_pkg::ST_WAKE && !selStable |=> !cpuRunEn)
        else $error("core released before clock stable");

endmodule : blpm_ctrl

// ---- blpm_pkg.sv ----
// Purpose: Shared constants and types of the boot and low-power controller
// Assumes: 40 MHz core_clk, synchronous active-high reset
// Notes: Register offsets are byte addresses on the plain register port
//
// Functional notes
// [RULE_01] Sample boot pin at release; low boots flash
// [RULE_02] Boot pin high starts the factory loader
// [RULE_03] Boot pin must settle before reset release
// [RULE_04] Fetch stack from word 0, vector from 4
// [RULE_05] Reset gates all clocks but tick, RAM
// [RULE_06] Software enables peripheral clocks before use
// [RULE_07] Writes dropped silently while config clock gated
// [RULE_08] Gated working clock stops peripheral function
// [RULE_09] Power-up lands in active mode
// [RULE_10] Sleep halts core, peripherals and pins untouched
// [RULE_11] Deep sleep halts core, stops fast oscillators
// [RULE_12] Wait instruction enters sleep or deep sleep
// [RULE_13] Sleep after handler enters on lowest return
// [RULE_14] Enabled interrupt wakes back to active
// [RULE_15] Brownout on either supply holds reset
// [RULE_16] Software moves clocks to slow oscillator first
// [RULE_17] Software waits for idle flash first
// [RULE_18] Software enables wake interrupt beforehand
// [RULE_19] Wake clock select forces internal fast clock
// [RULE_20] Core held until wake clock stable
package blpm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG_EN = 8'h04;
    localparam logic [7:0] OFS_WORK_EN = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;

    // Control register fields
    localparam int CTRL_DEEP_SEL = 0;
    localparam int CTRL_SLEEP_AFTER = 1;
    localparam int CTRL_WAKE_CLK = 2;
    localparam int CTRL_CLK_SEL = 4;
    localparam int CTRL_EXT_FAST = 8;
    localparam int CTRL_INT_FAST = 9;
    localparam int CTRL_EXT_SLOW = 10;
    localparam int CTRL_INT_SLOW = 11;

    // Status register fields
    localparam int STAT_STATE = 0;
    localparam int STAT_LOADER = 4;
    localparam int STAT_EXT_OK = 5;
    localparam int STAT_INT_OK = 6;

    // Reset values
    localparam logic [31:0] RST_CLK_EN = 32'h00000000;
    localparam logic [31:0] RST_IRQ_EN = 32'h00000000;
    localparam logic RST_INT_FAST = 1'b1;

    // Peripherals whose clocks stay on through reset
    localparam int TICK_IDX = 0;
    localparam int SRAM_IDX = 1;

    // Start-up fetch addresses and boot region bases
    localparam logic [31:0] ADDR_STACK = 32'h00000000;
    localparam logic [31:0] ADDR_VECTOR = 32'h00000004;
    localparam logic [31:0] BASE_FLASH = 32'h00000000;
    localparam logic [31:0] BASE_LOADER = 32'h00100000;

    // Oscillator settle time after its ready flag rises
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_CAPT = 3'h0,
        ST_FSP = 3'h1,
        ST_FPC = 3'h2,
        ST_LPC = 3'h3,
        ST_ACTIVE = 3'h4,
        ST_SLEEP = 3'h5,
        ST_DEEP = 3'h6,
        ST_WAKE = 3'h7
    } blpm_state_t;

    typedef enum logic [1:0] {
        CLK_INT = 2'h0,
        CLK_EXT = 2'h1,
        CLK_SLOW = 2'h2
    } blpm_clk_t;

endpackage : blpm_pkg

// ---- blpm_osc_ctrl.sv ----
// Purpose: Enable and settle tracking for one fast oscillator
// Assumes: Ready flag synchronous to core_clk
// Notes: Stable only after the ready flag stays high for SETTLE cycles
`timescale 1ns/100ps
module blpm_osc_ctrl #(
    parameter int SETTLE = blpm_pkg::SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic swEn,
    input wire logic forceOn,
    input wire logic forceOff,
    input wire logic oscRdy,
    output logic oscEn,
    output logic oscStable
);
    // Elaboration-time refusal of settle counts the counter cannot hold
    if (SETTLE < 1 || SETTLE > 65535) begin : g_settle_chk
        $error("blpm_osc_ctrl: SETTLE out of range");
    end

    logic [15:0] cnt_r;
    logic enable;

    ////////////////////////////////////////////////////////////////////////
    // Stop request beats every keep-on request
    assign enable = (swEn | forceOn) & ~forceOff;
    assign oscStable = (cnt_r == 16'(SETTLE));

    // Counter restarts whenever the oscillator drops or loses ready
    always_ff @(posedge core_clk) begin
        if (srst || !enable || !oscRdy) begin
            cnt_r <= 16'h0000;
        end else if (!oscStable) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            oscEn <= 1'b0;
        end else begin
            oscEn <= enable;
        end
    end

endmodule : blpm_osc_ctrl

// ---- blpm_periph_gate.sv ----
// Purpose: Peripheral configuration and working clock gates
// Assumes: Enable words come from registers
// Notes: Tick timer and RAM clocks can never be switched off
`timescale 1ns/100ps
module blpm_periph_gate #(
    parameter int NP = 32
) (
    input wire logic [NP-1:0] cfgEnReg,
    input wire logic [NP-1:0] workEnReg,
    input wire logic [NP-1:0] periphWrReq,
    output logic [NP-1:0] cfgClkEn,
    output logic [NP-1:0] workClkEn,
    output logic [NP-1:0] periphWrEn
);
    // Elaboration-time refusal of a width without the always-on bits
    if (NP <= blpm_pkg::SRAM_IDX || NP <= blpm_pkg::TICK_IDX) begin : g_np_chk
        $error("blpm_periph_gate: NP too small");
    end

    wire [NP-1:0] onMask = (NP'(1) << blpm_pkg::TICK_IDX)
                         | (NP'(1) << blpm_pkg::SRAM_IDX);

    ////////////////////////////////////////////////////////////////////////
    // Always-on clocks ORed in; a write to a gated block simply vanishes
    assign cfgClkEn = cfgEnReg | onMask; // [RULE_05]
    assign workClkEn = workEnReg | onMask; // [RULE_08]
    assign periphWrEn = periphWrReq & cfgClkEn; // [RULE_07]

endmodule : blpm_periph_gate

// ---- blpm_core_model.sv ----
// Purpose: Core-side memory and fast oscillator stand-in
// Assumes: Fetch data is due the cycle after memRd
// Notes: Idle data bus shows the inverse of its last word
`timescale 1ns/100ps
module blpm_core_model #(
    parameter logic [31:0] STACK = 32'h20005FF0,
    parameter logic [31:0] VECT = 32'h000000C1
) (
    input wire logic core_clk,
    input wire logic memRd,
    input wire logic [31:0] memAddr,
    output logic [31:0] memRdata,
    input wire logic extFastOscEn,
    input wire logic intFastOscEn,
    output logic extFastOscRdy,
    output logic intFastOscRdy
);
    logic [2:0] extSh = 3'h0;
    logic [2:0] intSh = 3'h0;
    wire logic isVec = (memAddr == blpm_pkg::ADDR_VECTOR);

    ////////////////////////////////////////////////////////////////////////
    // Word 0 holds the stack top, word 4 the entry point
    initial memRdata = 32'h0;
    always @(posedge core_clk) begin
        if (memRd) begin
            memRdata <= isVec ? VECT : STACK;
        end else begin
            memRdata <= ~memRdata; // No stale word when not read
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready three edges after enable, lost at once when disabled
    always @(posedge core_clk) begin
        extSh <= {extSh[1:0], extFastOscEn};
        intSh <= {intSh[1:0], intFastOscEn};
    end
    assign extFastOscRdy = extSh[2] & extFastOscEn;
    assign intFastOscRdy = intSh[2] & intFastOscEn;
endmodule : blpm_core_model

// ---- test_blpm_ctrl.sv ----
// Purpose: Self-checking bench of boot and low-power control
// Assumes: SETTLE shortened to 2 cycles
// Notes: Register tasks keep one-cycle strobes
`timescale 1ns/100ps
module test_blpm_ctrl;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic borVddLow = 1'b0;
    logic borVddaLow = 1'b0;
    logic bootSelPin = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic cpuWfi = 1'b0;
    logic cpuExitLowest = 1'b0;
    logic [31:0] irqPending = 32'h0;
    logic [31:0] periphWrReq = 32'h0;
    logic [31:0] regRdata, memAddr, memRdata, bootBase, cpuStackPtr;
    logic [31:0] cpuResetPc, periphWrEn, cfgClkEn, workClkEn, d;
    logic memRd, cpuRunEn, extFastOscEn, intFastOscEn, extSlowOscEn;
    logic intSlowOscEn, extFastOscRdy, intFastOscRdy, sysRstOut;
    logic [1:0] sysClkSel;
    int fail_count = 0;
    int check_count = 0;

    blpm_ctrl #(.NP(32), .SETTLE(2)) i_blpm_ctrl (.core_clk(core_clk),
        .srst(srst), .borVddLow(borVddLow), .borVddaLow(borVddaLow),
        .bootSelPin(bootSelPin), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .memRd(memRd),
        .memAddr(memAddr), .memRdata(memRdata), .bootBase(bootBase),
        .cpuStackPtr(cpuStackPtr), .cpuResetPc(cpuResetPc),
        .cpuRunEn(cpuRunEn), .cpuWfi(cpuWfi), .cpuExitLowest(cpuExitLowest),
        .irqPending(irqPending), .extFastOscEn(extFastOscEn),
        .intFastOscEn(intFastOscEn), .extSlowOscEn(extSlowOscEn),
        .intSlowOscEn(intSlowOscEn), .extFastOscRdy(extFastOscRdy),
        .intFastOscRdy(intFastOscRdy), .sysClkSel(sysClkSel),
        .periphWrReq(periphWrReq), .periphWrEn(periphWrEn),
        .cfgClkEn(cfgClkEn), .workClkEn(workClkEn), .sysRstOut(sysRstOut));

    blpm_core_model i_blpm_core_model (.core_clk(core_clk), .memRd(memRd),
        .memAddr(memAddr), .memRdata(memRdata),
        .extFastOscEn(extFastOscEn), .intFastOscEn(intFastOscEn),
        .extFastOscRdy(extFastOscRdy), .intFastOscRdy(intFastOscRdy));

    ////////////////////////////////////////////////////////////////////////
    // Clock and shared tasks
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        v = regRdata;
    endtask : rd

    task automatic core_evt(input logic exitEvt);
        @(posedge core_clk);
        cpuWfi <= ~exitEvt;
        cpuExitLowest <= exitEvt;
        @(posedge core_clk);
        cpuWfi <= 1'b0;
        cpuExitLowest <= 1'b0;
        #1;
    endtask : core_evt

    task automatic irq(input logic [31:0] v);
        @(posedge core_clk);
        irqPending <= v;
    endtask : irq

    // Bounded wait for the core to be let run again
    task automatic wait_run();
        int n;
        n = 0;
        while (cpuRunEn !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        chk("wake run", 32'h1, {31'h0, cpuRunEn});
    endtask : wait_run

    // Reset from srst or either supply flag, pin moved after capture
    task automatic do_reset(input int src, input logic pin);
        @(posedge core_clk);
        bootSelPin <= pin;
        srst <= (src == 0);
        borVddLow <= (src == 1);
        borVddaLow <= (src == 2);
        step(1);
        chk("reset out", 32'h1, {31'h0, sysRstOut});
        chk("run in reset", 32'h0, {31'h0, cpuRunEn});
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        borVddLow <= 1'b0;
        borVddaLow <= 1'b0;
        @(posedge core_clk);
        bootSelPin <= ~pin;
        step(5);
        chk("run", 32'h1, {31'h0, cpuRunEn});
        chk("base", pin ? blpm_pkg::BASE_LOADER : blpm_pkg::BASE_FLASH,
            bootBase);
        chk("stack", 32'h20005FF0, cpuStackPtr);
        chk("vector", 32'h000000C1, cpuResetPc);
        chk("cfg clk", 32'h3, cfgClkEn);
        chk("work clk", 32'h3, workClkEn);
        rd(blpm_pkg::OFS_STATUS, d);
        chk("status", {27'h0, pin, 4'h4}, d & 32'h17);
    endtask : do_reset

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the roughly 140 cycles of the tests
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset(0, 1'b0);
        @(posedge core_clk);
        periphWrReq <= 32'h20;
        step(1);
        chk("gated write", 32'h0, periphWrEn);
        wr(blpm_pkg::OFS_CFG_EN, 32'h20);
        step(1);
        chk("open write", 32'h20, periphWrEn);
        chk("work gated", 32'h3, workClkEn);
        rd(blpm_pkg::OFS_CFG_EN, d);
        chk("cfg read", 32'h20, d);
        wr(blpm_pkg::OFS_WORK_EN, 32'h20);
        step(1);
        chk("work open", 32'h23, workClkEn);
        rd(8'h3C, d);
        chk("unmapped", 32'h0, d);
        // Sleep by wait instruction, woken by enabled line only
        wr(blpm_pkg::OFS_IRQ_EN, 32'h1);
        wr(blpm_pkg::OFS_CTRL, 32'h200);
        core_evt(1'b1);
        chk("exit no sleep", 32'h1, {31'h0, cpuRunEn});
        core_evt(1'b0);
        chk("sleep", 32'h0, {31'h0, cpuRunEn});
        chk("sleep osc", 32'h1, {31'h0, intFastOscEn});
        chk("sleep clk", 32'h23, cfgClkEn);
        irq(32'h2);
        step(3);
        chk("masked irq", 32'h0, {31'h0, cpuRunEn});
        irq(32'h1);
        step(1);
        chk("sleep wake", 32'h1, {31'h0, cpuRunEn});
        irq(32'h0);
        // Deep sleep on handler exit, wake onto internal fast clock
        wr(blpm_pkg::OFS_CTRL, 32'hE07);
        step(4);
        core_evt(1'b1);
        chk("deep", 32'h0, {31'h0, cpuRunEn});
        step(2);
        chk("int fast off", 32'h0, {31'h0, intFastOscEn});
        chk("slow kept", 32'h1, {31'h0, extSlowOscEn});
        chk("int slow kept", 32'h1, {31'h0, intSlowOscEn});
        irq(32'h1);
        step(2);
        chk("held", 32'h0, {31'h0, cpuRunEn});
        chk("wake sel", 32'h0, {30'h0, sysClkSel});
        wait_run();
        chk("int ready", 32'h1, {31'h0, intFastOscRdy});
        irq(32'h0);
        // Deep sleep by wait instruction, external clock resumed
        wr(blpm_pkg::OFS_CTRL, 32'h300);
        step(10);
        wr(blpm_pkg::OFS_CTRL, 32'h311);
        step(10);
        chk("ext sel", 32'h1, {30'h0, sysClkSel});
        core_evt(1'b0);
        step(2);
        chk("ext fast off", 32'h0, {31'h0, extFastOscEn});
        irq(32'h1);
        step(2);
        chk("held ext", 32'h0, {31'h0, cpuRunEn});
        wait_run();
        chk("resume sel", 32'h1, {30'h0, sysClkSel});
        chk("ext ready", 32'h1, {31'h0, extFastOscRdy});
        irq(32'h0);
        // Slow system clock: wake needs no settle, one cycle in wake
        wr(blpm_pkg::OFS_CTRL, 32'h421);
        core_evt(1'b0);
        irq(32'h1);
        step(2);
        chk("slow wake", 32'h1, {31'h0, cpuRunEn});
        irq(32'h0);
        // Supply monitors reset the device, loader then flash boot
        do_reset(1, 1'b1);
        do_reset(2, 1'b0);
        complete_run();
    end
endmodule : test_blpm_ctrl
